// File: hdl/tir_pkg.sv
`default_nettype none
package tir_pkg;
  // ****************************************
  // Register indices on the plain port
  // ****************************************
  localparam logic [3:0] ADDR_TIMER_A = 4'h0;
  localparam logic [3:0] ADDR_TIMER_B_LOW = 4'h1;
  localparam logic [3:0] ADDR_TIMER_B_HIGH = 4'h2;
  localparam logic [3:0] ADDR_TIMER_C = 4'h3;
  localparam logic [3:0] ADDR_LOW_TIME = 4'h4;
  localparam logic [3:0] ADDR_HIGH_TIME = 4'h5;
  localparam logic [3:0] ADDR_TIME_SCALE = 4'h6;
  localparam logic [3:0] ADDR_PRESC_COUNT = 4'h7;
  localparam logic [3:0] ADDR_MAIN_TICK = 4'h8;
  localparam logic [3:0] ADDR_CONTROL = 4'h9;
  localparam logic [3:0] ADDR_MODE = 4'hA;
  localparam logic [3:0] ADDR_FLAGS = 4'hB;
  localparam logic [3:0] ADDR_IRQ_EN = 4'hC;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int HT_EN_BIT = 7;
  localparam int HT_CODE_LSB = 4;
  localparam int LT_EN_BIT = 3;
  localparam int LT_CODE_LSB = 0;
  localparam int MODE_EXTEND_BIT = 0;
  localparam int MODE_IRE_BIT = 1;
  localparam int MODE_HF_BIT = 2;
  localparam int MODE_TC_EN_BIT = 3;
  localparam int MODE_TC_CODE_LSB = 4;
  localparam int FLAG_A_BIT = 0;
  localparam int FLAG_B_BIT = 1;
  localparam int FLAG_C_BIT = 2;
  localparam int FLAG_LOW_BIT = 3;
  localparam int FLAG_HIGH_BIT = 4;
  localparam int IRQ_LOW_BIT = 0;
  localparam int IRQ_HIGH_BIT = 1;

  // ****************************************
  // Reset values and vectors
  // ****************************************
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [11:0] VEC_LOW_TIME = 12'h015;
  localparam logic [11:0] VEC_HIGH_TIME = 12'h012;
  localparam logic [11:0] VEC_NONE = 12'h000;

  typedef enum logic {
    SEG_HIGH = 1'b0,
    SEG_LOW = 1'b1
  } tir_seg_type;
endpackage : tir_pkg
`default_nettype wire

// File: hdl/tir_timers.sv
// Notes on behaviour
// RULE1: Timer A is an 8-bit readable, writable up counter, cleared by reset.
// RULE2: Timer B 8-bit overflows after 256 minus load clock cycles, unscaled.
// RULE3: Extend bit 0 idles high byte; 1 joins bytes into 16-bit timer.
// RULE4: Wide timer B overflows after 65536 minus load; both bytes read/write.
// RULE5: Timer C is an 8-bit readable, writable timer, cleared by reset.
// RULE6: Timer C is an up timer when high-frequency or infrared bit is 0.
// RULE7: Up timer C overflows after 256 minus load scaled ticks.
// RULE8: Both bits set: timer C makes carrier that fills low segments.
// RULE9: Carrier period is 2 x (1 + timer C) x timer C scale cycles.
// RULE10: Low segment lasts (1 + low-time) x low scale cycles.
// RULE11: Low counter underflow with enable raises interrupt at vector 015H.
// RULE12: High segment lasts (1 + high-time) x high scale cycles.
// RULE13: High counter underflow with enable raises interrupt at vector 012H.
// RULE14: Scale bit 7 enables high-time scaling, else 1:1.
// RULE15: High scale code in bits 6..4 gives ratio 2^(code+1).
// RULE16: Scale bit 3 enables low-time scaling, else 1:1.
// RULE17: Low scale code in bits 2..0 gives ratio 2^(code+1).
// RULE18: Prescaler count read/write; only low N bits matter for 1:2^N.
// RULE19: Writing main tick timer or prescaler select clears prescaler count.
// RULE20: Power-on, external and watchdog resets clear the prescaler count.
// RULE21: Timer C scale code gives 1:2 to 1:256, gated by its enable.
// RULE22: Infrared enable 0 holds output high; timer C is up timer.
// RULE23: Output alternates low and high segments; counters reload per segment.
// RULE24: Timers A, B, C set sticky flags on wrap until software clears.
// RULE25: Prescaler counts every clock; main tick steps on selected carry.
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`default_nettype none
module tir_timers (
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic WDT_TIMEOUT,
  output logic MODULATED_OUT,
  output logic LOW_TIME_INT,
  output logic HIGH_TIME_INT,
  output logic [11:0] INT_VECTOR
);

  typedef struct packed {
    logic [7:0] timer_a;
    logic [7:0] timer_b_low;
    logic [7:0] timer_b_high;
    logic [7:0] timer_c;
    logic [7:0] low_time;
    logic [7:0] high_time;
    logic [7:0] scale;
    logic [7:0] presc;
    logic [7:0] main_tick;
    logic [3:0] control;
    logic [6:0] mode;
    logic [4:0] flags;
    logic [1:0] irq_en;
    logic [7:0] tc_pre;
    logic [7:0] car_cnt;
    logic carrier;
    tir_pkg::tir_seg_type seg;
    logic [7:0] seg_cnt;
    logic [7:0] seg_pre;
    logic [2:0] wdt_sync;
    logic wdt_level;
    logic ire_q;
    logic [7:0] rdata;
    logic out;
    logic low_int;
    logic high_int;
    logic [11:0] vector;
  } tir_state_type;

  tir_state_type cur_ff;
  tir_state_type nxt_ff;

  // Mask of a scaled divider: ratio minus one, zero when scaling is off
  function automatic logic [7:0] scale_mask(input logic en,
                                            input logic [2:0] code);
    logic [8:0] full;
    full = 9'h002 << code;
    scale_mask = en ? 8'(full - 9'h001) : 8'h00;
  endfunction : scale_mask

  logic wr_a, wr_bl, wr_bh, wr_c, wr_lt, wr_ht, wr_sc, wr_ps;
  logic wr_mt, wr_ct, wr_md, wr_fl, wr_ie;
  logic extend, infrared_enable, hf, ir_mode;
  logic [7:0] tc_mask, lt_mask, ht_mask, ps_mask, seg_mask;
  logic tc_tick, seg_tick, b_low_wrap, b_wrap, seg_end, wdt_rst;
  logic [4:0] flag_set;

  always_comb begin
    wr_a = WR && ADDR == tir_pkg::ADDR_TIMER_A;
    wr_bl = WR && ADDR == tir_pkg::ADDR_TIMER_B_LOW;
    wr_bh = WR && ADDR == tir_pkg::ADDR_TIMER_B_HIGH;
    wr_c = WR && ADDR == tir_pkg::ADDR_TIMER_C;
    wr_lt = WR && ADDR == tir_pkg::ADDR_LOW_TIME;
    wr_ht = WR && ADDR == tir_pkg::ADDR_HIGH_TIME;
    wr_sc = WR && ADDR == tir_pkg::ADDR_TIME_SCALE;
    wr_ps = WR && ADDR == tir_pkg::ADDR_PRESC_COUNT;
    wr_mt = WR && ADDR == tir_pkg::ADDR_MAIN_TICK;
    wr_ct = WR && ADDR == tir_pkg::ADDR_CONTROL;
    wr_md = WR && ADDR == tir_pkg::ADDR_MODE;
    wr_fl = WR && ADDR == tir_pkg::ADDR_FLAGS;
    wr_ie = WR && ADDR == tir_pkg::ADDR_IRQ_EN;
    extend = cur_ff.mode[tir_pkg::MODE_EXTEND_BIT];
    infrared_enable = cur_ff.mode[tir_pkg::MODE_IRE_BIT];
    hf = cur_ff.mode[tir_pkg::MODE_HF_BIT];
    ir_mode = infrared_enable && hf; // [RULE6] [RULE8]
    tc_mask = scale_mask(cur_ff.mode[tir_pkg::MODE_TC_EN_BIT],
      cur_ff.mode[tir_pkg::MODE_TC_CODE_LSB +: 3]); // [RULE21]
    lt_mask = scale_mask(cur_ff.scale[tir_pkg::LT_EN_BIT],
      cur_ff.scale[tir_pkg::LT_CODE_LSB +: 3]); // [RULE16] [RULE17]
    ht_mask = scale_mask(cur_ff.scale[tir_pkg::HT_EN_BIT],
      cur_ff.scale[tir_pkg::HT_CODE_LSB +: 3]); // [RULE14] [RULE15]
    // Low N bits of the prescaler, N = select + 1
    ps_mask = 8'((9'h002 << cur_ff.control[2:0]) - 9'h001); // [RULE18]
    seg_mask = cur_ff.seg == tir_pkg::SEG_LOW ? lt_mask : ht_mask;
    tc_tick = cur_ff.tc_pre == tc_mask;
    seg_tick = cur_ff.seg_pre == seg_mask;
    seg_end = infrared_enable && seg_tick && cur_ff.seg_cnt == 8'h00;
    b_low_wrap = cur_ff.timer_b_low == 8'hFF;
    b_wrap = b_low_wrap && (!extend || cur_ff.timer_b_high == 8'hFF);
    // Watchdog pin counts only once the two late stages agree
    wdt_rst = cur_ff.wdt_sync[1] && cur_ff.wdt_sync[2] && !cur_ff.wdt_level;
  end

  always_comb begin
    nxt_ff = cur_ff;
    flag_set = '0;
    // ****************************************
    // Watchdog reset synchroniser
    // ****************************************
    nxt_ff.wdt_sync = {cur_ff.wdt_sync[1:0], WDT_TIMEOUT};
    nxt_ff.ire_q = infrared_enable;
    if (cur_ff.wdt_sync[1] == cur_ff.wdt_sync[2]) begin
      nxt_ff.wdt_level = cur_ff.wdt_sync[2];
    end

    // ****************************************
    // Timer A and timer B
    // ****************************************
    nxt_ff.timer_a = cur_ff.timer_a + 8'h01; // [RULE1]
    flag_set[tir_pkg::FLAG_A_BIT] = cur_ff.timer_a == 8'hFF; // [RULE24]
    nxt_ff.timer_b_low = cur_ff.timer_b_low + 8'h01; // [RULE2]
    if (extend && b_low_wrap) begin
      nxt_ff.timer_b_high = cur_ff.timer_b_high + 8'h01; // [RULE3] [RULE4]
    end
    flag_set[tir_pkg::FLAG_B_BIT] = b_wrap; // [RULE24]

    // ****************************************
    // Timer C: up timer or carrier generator
    // ****************************************
    nxt_ff.tc_pre = tc_tick ? 8'h00 : cur_ff.tc_pre + 8'h01; // [RULE7]
    if (!ir_mode) begin
      nxt_ff.carrier = 1'b0;
      nxt_ff.car_cnt = 8'h00;
      if (tc_tick) begin
        nxt_ff.timer_c = cur_ff.timer_c + 8'h01; // [RULE6] [RULE7] [RULE22]
        flag_set[tir_pkg::FLAG_C_BIT] = cur_ff.timer_c == 8'hFF; // [RULE24]
      end
    end else if (tc_tick && cur_ff.ire_q) begin
      // Register keeps the half-period; a private counter runs it
      // First half-period starts one edge late, as the output does
      if (cur_ff.car_cnt == cur_ff.timer_c) begin
        nxt_ff.car_cnt = 8'h00;
        nxt_ff.carrier = !cur_ff.carrier; // [RULE9]
      end else begin
        nxt_ff.car_cnt = cur_ff.car_cnt + 8'h01;
      end
    end

    // ****************************************
    // Pulse generator
    // ****************************************
    // The edge that turns the output low must not count, else the first
    // low segment comes out one cycle short
    if (!infrared_enable || !cur_ff.ire_q) begin
      nxt_ff.seg = tir_pkg::SEG_LOW;
      nxt_ff.seg_cnt = cur_ff.low_time;
      nxt_ff.seg_pre = 8'h00;
    end else begin
      nxt_ff.seg_pre = seg_tick ? 8'h00 : cur_ff.seg_pre + 8'h01;
      if (seg_end) begin
        case (cur_ff.seg)
          tir_pkg::SEG_LOW: begin
            nxt_ff.seg = tir_pkg::SEG_HIGH;
            nxt_ff.seg_cnt = cur_ff.high_time; // [RULE23] [RULE12]
            flag_set[tir_pkg::FLAG_LOW_BIT] = 1'b1; // [RULE11]
          end
          tir_pkg::SEG_HIGH: begin
            nxt_ff.seg = tir_pkg::SEG_LOW;
            nxt_ff.seg_cnt = cur_ff.low_time; // [RULE23] [RULE10]
            flag_set[tir_pkg::FLAG_HIGH_BIT] = 1'b1; // [RULE13]
          end
          default: begin
            nxt_ff.seg = tir_pkg::SEG_LOW;
            nxt_ff.seg_cnt = cur_ff.low_time;
          end
        endcase
      end else if (seg_tick) begin
        nxt_ff.seg_cnt = cur_ff.seg_cnt - 8'h01;
      end
    end
    if (!infrared_enable) begin
      nxt_ff.out = 1'b1; // [RULE22]
    end else if (nxt_ff.seg == tir_pkg::SEG_HIGH) begin
      nxt_ff.out = 1'b1;
    end else begin
      nxt_ff.out = ir_mode ? nxt_ff.carrier : 1'b0; // [RULE8] [RULE10]
    end

    // ****************************************
    // Main tick timer and its prescaler
    // ****************************************
    nxt_ff.presc = cur_ff.presc + 8'h01; // [RULE25]
    if ((cur_ff.presc & ps_mask) == ps_mask) begin
      nxt_ff.main_tick = cur_ff.main_tick + 8'h01; // [RULE25]
    end

    // ****************************************
    // Software writes win over counting
    // ****************************************
    if (wr_a) nxt_ff.timer_a = WDATA; // [RULE1]
    if (wr_bl) nxt_ff.timer_b_low = WDATA; // [RULE4]
    if (wr_bh) nxt_ff.timer_b_high = WDATA; // [RULE4]
    if (wr_c) nxt_ff.timer_c = WDATA; // [RULE5]
    if (wr_lt) nxt_ff.low_time = WDATA;
    if (wr_ht) nxt_ff.high_time = WDATA;
    if (wr_sc) nxt_ff.scale = WDATA;
    if (wr_ps) nxt_ff.presc = WDATA; // [RULE18]
    if (wr_mt) nxt_ff.main_tick = WDATA;
    if (wr_ct) nxt_ff.control = WDATA[3:0];
    if (wr_md) nxt_ff.mode = WDATA[6:0];
    if (wr_ie) nxt_ff.irq_en = WDATA[1:0];
    if (wr_mt || wr_ct) nxt_ff.presc = 8'h00; // [RULE19]
    if (wdt_rst) begin
      // Watchdog reset clears the same state as the pin reset, but keeps its synchroniser stages and sets the watchdog level
      nxt_ff = '0;
      nxt_ff.wdt_sync = cur_ff.wdt_sync; // [RULE20]
      nxt_ff.wdt_level = 1'b1;
      nxt_ff.out = 1'b1;
      flag_set = '0;
    end
    // A flag set in the same cycle as its clear stays set
    nxt_ff.flags = ((wr_fl && !wdt_rst) ? cur_ff.flags & ~WDATA[4:0]
      : nxt_ff.flags) | flag_set; // [RULE24]

    // ****************************************
    // Interrupt requests and read data
    // ****************************************
    nxt_ff.low_int = nxt_ff.flags[tir_pkg::FLAG_LOW_BIT]
      && nxt_ff.irq_en[tir_pkg::IRQ_LOW_BIT]; // [RULE11]
    nxt_ff.high_int = nxt_ff.flags[tir_pkg::FLAG_HIGH_BIT]
      && nxt_ff.irq_en[tir_pkg::IRQ_HIGH_BIT]; // [RULE13]
    // Low-time request takes precedence when both are pending
    nxt_ff.vector = nxt_ff.low_int ? tir_pkg::VEC_LOW_TIME
      : nxt_ff.high_int ? tir_pkg::VEC_HIGH_TIME : tir_pkg::VEC_NONE;
    nxt_ff.rdata = 8'h00;
    if (RD) begin
      case (ADDR)
        tir_pkg::ADDR_TIMER_A: nxt_ff.rdata = cur_ff.timer_a;
        tir_pkg::ADDR_TIMER_B_LOW: nxt_ff.rdata = cur_ff.timer_b_low;
        tir_pkg::ADDR_TIMER_B_HIGH: nxt_ff.rdata = cur_ff.timer_b_high;
        tir_pkg::ADDR_TIMER_C: nxt_ff.rdata = cur_ff.timer_c;
        tir_pkg::ADDR_LOW_TIME: nxt_ff.rdata = cur_ff.low_time;
        tir_pkg::ADDR_HIGH_TIME: nxt_ff.rdata = cur_ff.high_time;
        tir_pkg::ADDR_TIME_SCALE: nxt_ff.rdata = cur_ff.scale;
        tir_pkg::ADDR_PRESC_COUNT: nxt_ff.rdata = cur_ff.presc; // [RULE18]
        tir_pkg::ADDR_MAIN_TICK: nxt_ff.rdata = cur_ff.main_tick;
        tir_pkg::ADDR_CONTROL: nxt_ff.rdata = {4'h0, cur_ff.control};
        tir_pkg::ADDR_MODE: nxt_ff.rdata = {1'b0, cur_ff.mode};
        tir_pkg::ADDR_FLAGS: nxt_ff.rdata = {3'h0, cur_ff.flags};
        tir_pkg::ADDR_IRQ_EN: nxt_ff.rdata = {6'h00, cur_ff.irq_en};
        default: nxt_ff.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      cur_ff <= '0; // [RULE1] [RULE4] [RULE5] [RULE20]
      cur_ff.out <= 1'b1;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign RDATA = cur_ff.rdata;
  assign MODULATED_OUT = cur_ff.out;
  assign LOW_TIME_INT = cur_ff.low_int;
  assign HIGH_TIME_INT = cur_ff.high_int;
  assign INT_VECTOR = cur_ff.vector;

endmodule : tir_timers
`default_nettype wire

// File: bench/tir_ir_load.sv
`default_nettype none
module tir_ir_load (
  input wire logic clk,
  input wire logic rstn,
  input wire logic pin,
  output logic done_ff,
  output logic lvl_ff,
  output logic [15:0] len_ff
);
  // An emitter only loads the line, so it reports each finished run
  logic [15:0] cnt_ff;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= 16'h0000;
      done_ff <= 1'b0;
      lvl_ff <= 1'b1;
      len_ff <= 16'h0000;
    end else begin
      done_ff <= pin != lvl_ff;
      if (pin != lvl_ff) begin
        len_ff <= cnt_ff;
        cnt_ff <= 16'h0001;
      end else cnt_ff <= cnt_ff + 16'h0001;
      lvl_ff <= pin;
    end
  end
endmodule : tir_ir_load
`default_nettype wire

// File: bench/tir_timers_chk.sv
`default_nettype none
module tir_timers_chk (
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  input wire logic MODULATED_OUT,
  input wire logic LOW_TIME_INT,
  input wire logic HIGH_TIME_INT,
  input wire logic [11:0] INT_VECTOR
);
  // Shadow of the infrared enable; blind to watchdog clears, which only
  // weakens the idle check
  logic ire_ff;
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) ire_ff <= 1'b0;
    else if (WR && ADDR == tir_pkg::ADDR_MODE)
      ire_ff <= WDATA[tir_pkg::MODE_IRE_BIT];
  end
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);
  property p_vec_low; LOW_TIME_INT |-> INT_VECTOR == 12'h015; endproperty
  a_vec_low: assert property (p_vec_low)
    else $error("low vector wrong");
  property p_vec_high;
    !LOW_TIME_INT && HIGH_TIME_INT |-> INT_VECTOR == 12'h012;
  endproperty
  a_vec_high: assert property (p_vec_high)
    else $error("high vector wrong");
  property p_vec_none;
    !LOW_TIME_INT && !HIGH_TIME_INT |-> INT_VECTOR == 12'h000;
  endproperty
  a_vec_none: assert property (p_vec_none)
    else $error("vector without interrupt");
  property p_readback;
    (WR && ADDR <= 4'h7) ##1 (RD && ADDR == $past(ADDR))
      |=> RDATA == $past(WDATA, 2);
  endproperty
  a_readback: assert property (p_readback)
    else $error("register readback wrong");
  property p_presc_clr;
    (WR && (ADDR == 4'h8 || ADDR == 4'h9)) ##1 (RD && ADDR == 4'h7)
      |=> RDATA == 8'h00;
  endproperty
  a_presc_clr: assert property (p_presc_clr)
    else $error("prescaler not cleared");
  property p_ire_off; !ire_ff && !$past(ire_ff) |-> MODULATED_OUT; endproperty
  a_ire_off: assert property (p_ire_off)
    else $error("output low while idle");
  property p_flag_a;
    (WR && ADDR == 4'h0 && WDATA == 8'hFE) ##1 (WR && ADDR == 4'hB)
      ##2 (RD && ADDR == 4'hB) |=> RDATA[0];
  endproperty
  a_flag_a: assert property (p_flag_a)
    else $error("wrap flag missing");
  property p_rd_idle; !$past(RD) |-> RDATA == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read slot");
endmodule : tir_timers_chk
bind tir_timers tir_timers_chk chk (.SYS_CLK(SYS_CLK), .RSTN(RSTN),
  .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .MODULATED_OUT(MODULATED_OUT), .LOW_TIME_INT(LOW_TIME_INT),
  .HIGH_TIME_INT(HIGH_TIME_INT), .INT_VECTOR(INT_VECTOR));
`default_nettype wire

// File: bench/timers_and_ir_pulse_generator_tb.sv
`default_nettype none
module timers_and_ir_pulse_generator_tb;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
  logic SYS_CLK = 1'b0, RSTN = 1'b0, WR = 1'b0, RD = 1'b0;
  logic WDT_TIMEOUT = 1'b0, rd_d = 1'b0;
  logic [3:0] ADDR = 4'h0;
  logic [7:0] WDATA = 8'h00, RDATA, d, m, bh;
  logic MODULATED_OUT, LOW_TIME_INT, HIGH_TIME_INT, pdone, plvl;
  logic [11:0] INT_VECTOR;
  logic [15:0] plen, me;
  logic [15:0] rq[$];
  logic [16:0] pq[$];
  int errors = 0, comparisons = 0, l, h, ls, hs;
  always #50 SYS_CLK = ~SYS_CLK;
  tir_timers uut (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .WDT_TIMEOUT(WDT_TIMEOUT), .MODULATED_OUT(MODULATED_OUT),
    .LOW_TIME_INT(LOW_TIME_INT), .HIGH_TIME_INT(HIGH_TIME_INT),
    .INT_VECTOR(INT_VECTOR));
  tir_ir_load load (.clk(SYS_CLK), .rstn(RSTN), .pin(MODULATED_OUT),
    .done_ff(pdone), .lvl_ff(plvl), .len_ff(plen));
  // ****
  // Result watcher
  // ****
  always @(posedge SYS_CLK) rd_d <= RD;
  always @(negedge SYS_CLK) begin
    if (rd_d) begin
      me = rq.pop_front();
      `CHK(RDATA & me[15:8], me[7:0])
    end
    if (pdone && pq.size() > 0 && pq[0][16] == !plvl) begin
      `CHK(plen, pq[0][15:0])
      void'(pq.pop_front());
    end
  end
  task automatic bus(input logic w, input logic r, input logic [3:0] a,
                     input logic [7:0] dd, input logic [15:0] e);
    WR <= w;
    RD <= r;
    ADDR <= a;
    WDATA <= dd;
    if (r) rq.push_back(e);
    @(posedge SYS_CLK);
  endtask : bus
  task automatic wr(input logic [3:0] a, input logic [7:0] dd);
    bus(1'b1, 1'b0, a, dd, 16'h0000);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] k, e);
    bus(1'b0, 1'b1, a, 8'h00, {k, e});
  endtask : rd
  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 4'h0, 8'h00, 16'h0000);
  endtask : idle
  // Idle high runs fail the level match; cut-off runs find the queue empty
  task automatic run_ir(input logic [7:0] mode);
    wr(tir_pkg::ADDR_MODE, mode);
    for (int k = 0; k < 5000 && pq.size() > 0; k++) idle(1);
    `CHK(pq.size(), 0)
    wr(tir_pkg::ADDR_MODE, 8'h00);
    idle(2);
  endtask : run_ir
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done
  initial begin
    #3000000;
    errors++;
    test_done();
  end
  initial begin
    void'($urandom(32'h570C));
    repeat (8) @(posedge SYS_CLK);
    RSTN <= 1'b1;
    for (int i = 0; i < 16; i++) rd(i[3:0], (i == 8) ? 8'h00 : 8'hFF,
      (i < 2 || i == 3 || i == 7) ? i[7:0] : 8'h00);
    $display("reset values done");
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom());
      if (i == 2) bh = d;
      wr(i[3:0], d);
      rd(i[3:0], 8'hFF, d);
    end
    $display("readback done");
    for (int i = 0; i < 3; i++) begin
      m = 8'h01 << i;
      wr((i == 2) ? 4'h3 : i[3:0], 8'hFE);
      wr(tir_pkg::ADDR_FLAGS, m);
      rd(tir_pkg::ADDR_FLAGS, m, 8'h00);
      rd(tir_pkg::ADDR_FLAGS, m, m);
    end
    rd(tir_pkg::ADDR_TIMER_B_HIGH, 8'hFF, bh);
    wr(tir_pkg::ADDR_MODE, 8'h01);
    wr(tir_pkg::ADDR_TIMER_B_LOW, 8'hFD);
    wr(tir_pkg::ADDR_TIMER_B_HIGH, 8'hFF);
    wr(tir_pkg::ADDR_FLAGS, 8'h02);
    rd(tir_pkg::ADDR_FLAGS, 8'h02, 8'h00);
    rd(tir_pkg::ADDR_FLAGS, 8'h02, 8'h02);
    rd(tir_pkg::ADDR_TIMER_B_HIGH, 8'hFF, 8'h00);
    wr(tir_pkg::ADDR_MODE, 8'h00);
    $display("overflow done");
    wr(tir_pkg::ADDR_CONTROL, 8'h02);
    wr(tir_pkg::ADDR_MAIN_TICK, 8'h00);
    rd(tir_pkg::ADDR_PRESC_COUNT, 8'h07, 8'h00);
    idle(6);
    rd(tir_pkg::ADDR_MAIN_TICK, 8'hFF, 8'h00);
    rd(tir_pkg::ADDR_MAIN_TICK, 8'hFF, 8'h01);
    $display("prescaler done");
    wr(tir_pkg::ADDR_IRQ_EN, 8'h03);
    for (int i = 0; i < 4; i++) begin
      l = $urandom_range(7);
      h = $urandom_range(7);
      d = (i == 3) ? 8'hFF : 8'($urandom());
      ls = d[3] ? 2 << d[2:0] : 1;
      hs = d[7] ? 2 << d[6:4] : 1;
      wr(tir_pkg::ADDR_LOW_TIME, l[7:0]);
      wr(tir_pkg::ADDR_HIGH_TIME, h[7:0]);
      wr(tir_pkg::ADDR_TIME_SCALE, d);
      pq.push_back({1'b0, 16'((1 + l) * ls)});
      pq.push_back({1'b1, 16'((1 + h) * hs)});
      run_ir(8'h02);
    end
    $display("pulse done");
    wr(tir_pkg::ADDR_LOW_TIME, 8'h1F);
    wr(tir_pkg::ADDR_TIME_SCALE, 8'h00);
    // Timer C still counts once on the edge that enters carrier mode
    wr(tir_pkg::ADDR_TIMER_C, 8'h03);
    pq.push_back({1'b0, 16'h0005});
    pq.push_back({1'b1, 16'h0005});
    run_ir(8'h06);
    $display("carrier done");
    wr(tir_pkg::ADDR_LOW_TIME, 8'h5A);
    WDT_TIMEOUT <= 1'b1;
    idle(6);
    WDT_TIMEOUT <= 1'b0;
    rd(tir_pkg::ADDR_LOW_TIME, 8'hFF, 8'h00);
    rd(tir_pkg::ADDR_IRQ_EN, 8'hFF, 8'h00);
    idle(2);
    $display("watchdog done");
    test_done();
  end
endmodule : timers_and_ir_pulse_generator_tb
`default_nettype wire
